// ### hdl/cycle_sync.sv
// Two flip-flop level synchroniser.
// Assumes an input that is stable for two destination clock edges.
`timescale 1ns/100ps
`default_nettype none

module cycle_sync
  import latency_pkg::*;
(
  input wire logic clock_in,
  input wire logic level_in,
  output logic level_out
);

  sync_state_t s_r;
  sync_state_t s_nxt;

  always_comb begin
    s_nxt.q1 = level_in;
    s_nxt.q2 = s_r.q1;
  end

  always_ff @(posedge clock_in) begin
    s_r <= s_nxt;
  end

  assign level_out = s_r.q2;

endmodule
`default_nettype wire

// ### hdl/latency_table_top.sv
// Read latency lookup: loads the row for the configured band, checks
// its code, hands the counts to the serial clock side, which times the
// mode, dummy and data phases of each supported read and flags the rest as unsupported.
// Assumes config inputs come from logic on clock_in; link inputs are
// driven on sck_in by the command decoder.
`timescale 1ns/100ps
`default_nettype none

module latency_table_top
  import latency_pkg::*;
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [1:0] latency_code_in,
  input wire logic [2:0] band_sel_in,
  input wire logic param_rd_in,
  input wire logic [`ROM_AW-1:0] param_addr_in,
  output logic [7:0] param_data_out,
  output logic param_valid_out,
  output logic param_busy_out,
  output logic table_ready_out,
  output logic code_match_out,
  output logic [7:0] band_limit_out,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic addr_end_in,
  input wire logic [2:0] read_cmd_in,
  output logic mode_phase_out,
  output logic dummy_phase_out,
  output logic data_phase_out,
  output logic unsupported_out
);

  // ========================================================
  // Crossings and parameter store
  core_state_t c_r;
  core_state_t c_nxt;
  link_state_t l_r;
  link_state_t l_nxt;
  logic [`ROM_AW-1:0] rom_addr;
  logic [7:0] rom_data;
  logic ack_core;
  logic req_link;
  logic rstn_link;
  logic reload;
  logic take_rd;
  logic [`ROM_AW-1:0] row_addr;
  logic [2:0] band_row;
  logic [7:0] cmd_mode;
  logic [7:0] cmd_dly;
  logic [7:0] mode_cnt [`CMD_COUNT];
  logic [7:0] dly_cnt [`CMD_COUNT];

  cycle_sync u_ack_sync (
    .clock_in(clock_in),
    .level_in(l_r.ack),
    .level_out(ack_core)
  );

  cycle_sync u_req_sync (
    .clock_in(sck_in),
    .level_in(c_r.req),
    .level_out(req_link)
  );

  cycle_sync u_rst_sync (
    .clock_in(sck_in),
    .level_in(rstn_in),
    .level_out(rstn_link)
  );

  param_rom u_rom (
    .clock_in(clock_in),
    .addr_in(rom_addr),
    .data_out(rom_data)
  );

  // ========================================================
  // Core side: config watch and row address
  always_comb begin
    reload = !c_r.loaded || (latency_code_in != c_r.code_seen) ||
             (band_sel_in != c_r.band_seen);
    take_rd = (c_r.st == C_IDLE) && !reload && param_rd_in;
  end

  always_comb begin
    if (c_r.band_seen > 3'(`ROW_COUNT - 1)) begin
      band_row = 3'(`ROW_COUNT - 1);
    end else begin
      band_row = c_r.band_seen;
    end
    row_addr = 7'(`ROW_BASE + 7'(band_row) * 7'(`ROW_LEN) + 7'(c_r.idx));
    rom_addr = (c_r.st == C_IDLE) ? param_addr_in : row_addr;
  end

  // ========================================================
  // Core side: row loader and parameter reads
  always_comb begin
    c_nxt = c_r;
    c_nxt.valid = take_rd;
    case (c_r.st)
      C_IDLE: begin
        if (reload) begin
          c_nxt.st = C_REQ;
          c_nxt.idx = 4'h0;
          c_nxt.code_seen = latency_code_in;
          c_nxt.band_seen = band_sel_in;
          c_nxt.loaded = 1'b1;
          c_nxt.ready = 1'b0;
        end
      end
      C_REQ: begin
        c_nxt.st = C_CAP;
      end
      C_CAP: begin
        if (c_r.idx == 4'h0) begin
          c_nxt.limit = rom_data;
        end else if (c_r.idx == 4'h1) begin
          c_nxt.match = (rom_data == 8'(c_r.code_seen));
        end else begin
          c_nxt.tbl[8*(13-int'(c_r.idx)) +: 8] = rom_data;
        end
        if (c_r.idx == 4'(`ROW_LEN - 1)) begin
          c_nxt.st = C_HAND;
          c_nxt.req = !c_r.req;
          if (!c_nxt.match) begin
            c_nxt.tbl = '1;
          end
        end else begin
          c_nxt.st = C_REQ;
          c_nxt.idx = 4'(c_r.idx + 4'h1);
        end
      end
      C_HAND: begin
        if (ack_core == c_r.req) begin
          c_nxt.st = C_IDLE;
          c_nxt.ready = 1'b1;
        end
      end
      default: begin
        c_nxt.st = C_IDLE;
      end
    endcase
    c_nxt.busy = (c_nxt.st != C_IDLE) || (reload && c_r.st == C_IDLE);
    if (!rstn_in) begin
      c_nxt = '0;
      c_nxt.st = C_IDLE;
      c_nxt.code_seen = `CODE_RESET;
      c_nxt.busy = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    c_r <= c_nxt;
  end

  // ========================================================
  // Link side: counts per read type from the handed-over table
  for (genvar g = 0; g < `CMD_COUNT; g++) begin : g_cnt
    assign mode_cnt[g] = l_r.tbl[8*(11-2*g) +: 8];
    assign dly_cnt[g] = l_r.tbl[8*(10-2*g) +: 8];
  end

  always_comb begin
    if (read_cmd_in < 3'(`CMD_COUNT)) begin
      cmd_mode = mode_cnt[read_cmd_in];
      cmd_dly = dly_cnt[read_cmd_in];
    end else begin
      cmd_mode = `NOT_SUPPORTED;
      cmd_dly = `NOT_SUPPORTED;
    end
  end

  // ========================================================
  // Link side: phase timer on the serial clock
  always_comb begin
    l_nxt = l_r;
    case (l_r.st)
      L_IDLE: begin
        if (req_link != l_r.ack) begin
          l_nxt.tbl = c_r.tbl;
          l_nxt.ack = req_link;
        end
        if (!cs_n_in && addr_end_in) begin
          if (cmd_mode == `NOT_SUPPORTED || cmd_dly == `NOT_SUPPORTED) begin
            l_nxt.st = L_BAD;
          end else if (cmd_mode != 8'h00) begin
            l_nxt.st = L_MODE;
            l_nxt.cnt = cmd_mode;
            l_nxt.dly = cmd_dly;
          end else if (cmd_dly != 8'h00) begin
            l_nxt.st = L_DUMMY;
            l_nxt.cnt = cmd_dly;
          end else begin
            l_nxt.st = L_DATA;
          end
        end
      end
      L_MODE: begin
        l_nxt.cnt = 8'(l_r.cnt - 8'h01);
        if (l_r.cnt == 8'h01) begin
          l_nxt.st = (l_r.dly != 8'h00) ? L_DUMMY : L_DATA;
          l_nxt.cnt = l_r.dly;
        end
      end
      L_DUMMY: begin
        l_nxt.cnt = 8'(l_r.cnt - 8'h01);
        if (l_r.cnt == 8'h01) begin
          l_nxt.st = L_DATA;
        end
      end
      L_DATA: begin
        l_nxt.st = L_DATA;
      end
      L_BAD: begin
        l_nxt.st = L_BAD;
      end
      default: begin
        l_nxt.st = L_IDLE;
      end
    endcase
    if (cs_n_in) begin
      l_nxt.st = L_IDLE;
    end
    l_nxt.mode = (l_nxt.st == L_MODE);
    l_nxt.dummy = (l_nxt.st == L_DUMMY);
    l_nxt.data = (l_nxt.st == L_DATA);
    l_nxt.bad = (l_nxt.st == L_BAD);
    if (!rstn_link) begin
      l_nxt = '0;
      l_nxt.st = L_IDLE;
      l_nxt.tbl = '1;
      l_nxt.ack = req_link;
    end
  end

  always_ff @(posedge sck_in) begin
    l_r <= l_nxt;
  end

  // ========================================================
  // Outputs
  assign param_data_out = rom_data;
  assign param_valid_out = c_r.valid;
  assign param_busy_out = c_r.busy;
  assign table_ready_out = c_r.ready;
  assign code_match_out = c_r.match;
  assign band_limit_out = c_r.limit;
  assign mode_phase_out = l_r.mode;
  assign dummy_phase_out = l_r.dummy;
  assign data_phase_out = l_r.data;
  assign unsupported_out = l_r.bad;

endmodule
`default_nettype wire

// ### hdl/param_rom.sv
// Read-only parameter space: latency table and padding parameter.
// Assumes one read address per cycle; data one cycle later.
`timescale 1ns/100ps
`default_nettype none

module param_rom
  import latency_pkg::*;
(
  input wire logic clock_in,
  input wire logic [`ROM_AW-1:0] addr_in,
  output logic [7:0] data_out
);

  rom_state_t s_r;
  rom_state_t s_nxt;

  localparam logic [8*`HDR_LEN-1:0] hdr_bytes = `HDR_BYTES;

  function automatic logic [7:0] rom_byte(input logic [`ROM_AW-1:0] a);
    logic [111:0] row;
    logic [6:0] rel;
    logic [2:0] r;
    logic [3:0] c;
    rom_byte = `FILL_BYTE;
    rel = 7'(a - `ROW_BASE);
    r = 3'(rel / 7'(`ROW_LEN));
    c = 4'(rel % 7'(`ROW_LEN));
    case (r)
      3'h0: row = `ROW_50;
      3'h1: row = `ROW_80;
      3'h2: row = `ROW_90;
      3'h3: row = `ROW_108;
      default: row = `ROW_133;
    endcase
    if (a < `ROW_BASE) begin
      rom_byte = hdr_bytes[8*(`HDR_LEN-1-int'(a)) +: 8];
    end else if (a < `ROW_END) begin
      rom_byte = row[8*(`ROW_LEN-1-int'(c)) +: 8];
    end else if (a == `PAD_BASE) begin
      rom_byte = `PAD_ID;
    end else if (a == 7'(`PAD_BASE + 7'h01)) begin
      rom_byte = `PAD_LEN;
    end
  endfunction

  always_comb begin
    s_nxt.data = rom_byte(addr_in);
  end

  always_ff @(posedge clock_in) begin
    s_r <= s_nxt;
  end

  assign data_out = s_r.data;

endmodule
`default_nettype wire

// ### include/latency_consts.svh
// Constants for the read latency lookup block.
// Assumes inclusion by bare name from package and design files.
`ifndef LATENCY_CONSTS_SVH
`define LATENCY_CONSTS_SVH

// ==========================================================
// Parameter space layout
`define ROM_AW 7
`define ROM_DEPTH 128
`define HDR_LEN 18
`define HDR_BYTES 144'h9056_060e_4643_0313_0b0c_3b3c_6b6c_bbbc_ebec
`define ROW_BASE 7'h12
`define ROW_LEN 14
`define ROW_COUNT 5
`define ROW_END 7'h58
`define PAD_BASE 7'h58
`define PAD_END 7'h68
`define PAD_ID 8'hf0
`define PAD_LEN 8'h0f
`define FILL_BYTE 8'hff
`define NOT_SUPPORTED 8'hff

// ==========================================================
// Rows: limit, code, then mode/latency per read type
`define ROW_50 112'h3203_0000_0000_0000_0000_0400_0201
`define ROW_80 112'h5000_ffff_0008_0008_0008_0400_0204
`define ROW_90 112'h5a01_ffff_0008_0008_0008_0401_0204
`define ROW_108 112'h6802_ffff_0008_0008_0008_0402_0205
`define ROW_133 112'h8502_ffff_0008_ffff_ffff_ffff_ffff

// ==========================================================
// Command indices and codes
`define CMD_COUNT 6
`define CODE_RESET 2'h0

`endif

// ### include/latency_pkg.sv
// Types shared by the read latency lookup block.
// Assumes latency_consts.svh is on the include path.
`include "latency_consts.svh"

package latency_pkg;

  typedef logic [95:0] cycle_table_t;

  typedef enum logic [1:0] {C_IDLE, C_REQ, C_CAP, C_HAND} core_st_t;
  typedef enum logic [2:0] {L_IDLE, L_MODE, L_DUMMY, L_DATA, L_BAD} link_st_t;

  typedef struct packed {
    logic [7:0] data;
  } rom_state_t;

  typedef struct packed {
    logic q1;
    logic q2;
  } sync_state_t;

  typedef struct packed {
    core_st_t st;
    logic [3:0] idx;
    logic [1:0] code_seen;
    logic [2:0] band_seen;
    logic loaded;
    cycle_table_t tbl;
    logic [7:0] limit;
    logic match;
    logic req;
    logic valid;
    logic busy;
    logic ready;
  } core_state_t;

  typedef struct packed {
    link_st_t st;
    logic [7:0] cnt;
    logic [7:0] dly;
    cycle_table_t tbl;
    logic ack;
    logic mode;
    logic dummy;
    logic data;
    logic bad;
  } link_state_t;

endpackage

// ### tb/latency_chk.sv
// Port assertions for the latency lookup top.
// Assumes a bind from the bench top file.
`timescale 1ns/100ps
`default_nettype none
module latency_chk (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [1:0] latency_code_in,
  input wire logic param_rd_in,
  input wire logic [6:0] param_addr_in,
  input wire logic [7:0] param_data_out,
  input wire logic param_valid_out,
  input wire logic table_ready_out,
  input wire logic code_match_out,
  input wire logic [7:0] band_limit_out,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic mode_phase_out,
  input wire logic dummy_phase_out,
  input wire logic data_phase_out,
  input wire logic unsupported_out
);
  // ==========
  // Properties
  sequence s_rd(logic [6:0] a);
    param_rd_in && param_addr_in == a ##1 param_valid_out;
  endsequence
  sequence s_row(logic [7:0] f);
    table_ready_out && code_match_out && band_limit_out == f;
  endsequence
  property p_pad_id;
    @(posedge clock_in) disable iff (!rstn_in)
    s_rd(7'h58) |-> param_data_out == 8'hf0;
  endproperty
  a_pad_id: assert property (p_pad_id) else $error("pad id");
  property p_pad_len;
    @(posedge clock_in) disable iff (!rstn_in)
    s_rd(7'h59) |-> param_data_out == 8'h0f;
  endproperty
  a_pad_len: assert property (p_pad_len) else $error("pad len");
  property p_code80;
    @(posedge clock_in) disable iff (!rstn_in)
    s_row(8'h50) |-> $past(latency_code_in) == 2'h0;
  endproperty
  a_code80: assert property (p_code80) else $error("code 80");
  property p_code90;
    @(posedge clock_in) disable iff (!rstn_in)
    s_row(8'h5a) |-> $past(latency_code_in) == 2'h1;
  endproperty
  a_code90: assert property (p_code90) else $error("code 90");
  property p_code108;
    @(posedge clock_in) disable iff (!rstn_in)
    s_row(8'h68) |-> $past(latency_code_in) == 2'h2;
  endproperty
  a_code108: assert property (p_code108) else $error("code 108");
  property p_unsup_hold;
    @(posedge sck_in) disable iff (!rstn_in)
    unsupported_out && !cs_n_in |=> unsupported_out;
  endproperty
  a_unsup_hold: assert property (p_unsup_hold) else $error("unsup");
  property p_data_hold;
    @(posedge sck_in) disable iff (!rstn_in)
    data_phase_out && !cs_n_in |=> data_phase_out;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data");
  property p_cs_idle;
    @(posedge sck_in) disable iff (!rstn_in)
    cs_n_in |=> !(mode_phase_out || dummy_phase_out || data_phase_out);
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("idle");
endmodule
`default_nettype wire

// ### tb/spi_host_model.sv
// Host side: frames one read and counts phase cycles.
// Assumes sck stands low outside frames and bench calls.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  output logic sck_out,
  output logic cs_n_out,
  output logic addr_end_out,
  output logic [2:0] cmd_out,
  input wire logic mode_in,
  input wire logic dummy_in,
  input wire logic data_in,
  input wire logic unsup_in
);
  initial begin
    sck_out = 0;
    cs_n_out = 1;
    addr_end_out = 0;
    cmd_out = 3'h7;
  end
  // ==========
  // Link tasks
  task automatic rise();
    #23 sck_out = 0;
    #24 sck_out = 1;
    #1;
  endtask
  task automatic run(input int n);
    repeat (n) rise();
    #23 sck_out = 0;
  endtask
  task automatic read(input logic [2:0] cmd, output logic [7:0] m,
    output logic [7:0] d, output logic u);
    m = 0;
    d = 0;
    cs_n_out = 0;
    addr_end_out = 1;
    cmd_out = cmd;
    rise();
    addr_end_out = 0;
    cmd_out = ~cmd;
    repeat (24) begin
      m += mode_in;
      d += dummy_in;
      if (data_in || unsup_in) break;
      rise();
    end
    rise();
    u = unsup_in;
    cs_n_out = 1;
    run(1);
  endtask
endmodule
`default_nettype wire

// ### tb/tb_latency_table_top.sv
// Bench for the latency lookup top with the host model on the link.
// Assumes package, design, model and checker compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_latency_table_top;
  logic clock_in = 0;
  logic rstn_in = 0;
  logic [1:0] latency_code_in = 2'h0;
  logic [2:0] band_sel_in = 3'h1;
  logic param_rd_in = 0;
  logic [6:0] param_addr_in = 7'h00;
  logic [7:0] param_data_out, band_limit_out, m, d;
  logic param_valid_out, param_busy_out, table_ready_out, code_match_out;
  logic sck_in, cs_n_in, addr_end_in, u;
  logic [2:0] read_cmd_in;
  logic mode_phase_out, dummy_phase_out, data_phase_out, unsupported_out;
  logic [4:0] cur = 5'h1f;
  int mismatches = 0;
  int n_checks = 0;
  logic [23:0] rows [19] = '{
    24'h20ffff, 24'h210008, 24'h220008, 24'h230008,
    24'h240400, 24'h250204,
    24'h4c0401, 24'h4d0204, 24'h4b0008,
    24'h740402, 24'h750205, 24'h720008,
    24'h910008, 24'h93ffff, 24'h94ffff,
    24'h44ffff, 24'h26ffff, 24'h180000, 24'hb10008};
  logic [14:0] prows [8] = '{{7'h58, 8'hf0}, {7'h59, 8'h0f},
    {7'h5a, 8'hff}, {7'h68, 8'hff}, {7'h23, 8'hff}, {7'h2f, 8'h01},
    {7'h39, 8'h01}, {7'h49, 8'h05}};
  always #12.5 clock_in = ~clock_in;
  latency_table_top dut (.clock_in, .rstn_in, .latency_code_in,
    .band_sel_in, .param_rd_in, .param_addr_in, .param_data_out,
    .param_valid_out, .param_busy_out, .table_ready_out, .code_match_out,
    .band_limit_out, .sck_in, .cs_n_in, .addr_end_in, .read_cmd_in,
    .mode_phase_out, .dummy_phase_out, .data_phase_out, .unsupported_out);
  spi_host_model u_host (.sck_out(sck_in), .cs_n_out(cs_n_in),
    .addr_end_out(addr_end_in), .cmd_out(read_cmd_in),
    .mode_in(mode_phase_out), .dummy_in(dummy_phase_out),
    .data_in(data_phase_out), .unsup_in(unsupported_out));
  // ==========
  // Tasks
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic prd(input logic [6:0] a, input logic [7:0] e);
    @(posedge clock_in);
    param_rd_in <= 1;
    param_addr_in <= a;
    @(posedge clock_in);
    param_rd_in <= 0;
    #1 chk(param_valid_out, 1);
    chk(param_data_out, e);
  endtask
  task automatic set_cfg(input logic [2:0] b, input logic [1:0] c);
    logic [9:0] e;
    e = b == 0 ? 10'h0cb : b == 1 ? 10'h140 : b == 2 ? 10'h169 :
      b == 3 ? 10'h1a2 : 10'h216;
    @(posedge clock_in);
    band_sel_in <= b;
    latency_code_in <= c;
    repeat (3) @(posedge clock_in);
    for (int i = 0; i < 100 && table_ready_out !== 1; i++) u_host.run(1);
    chk(table_ready_out, 1);
    chk(param_busy_out, 0);
    chk(band_limit_out, e[9:2]);
    chk(code_match_out, e[1:0] == c);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #300000;
    mismatches++;
    summarize();
  end
  initial begin
    fork
      u_host.run(8);
      repeat (4) @(posedge clock_in);
    join
    chk(param_busy_out, 1);
    chk(table_ready_out, 0);
    chk(band_limit_out, 0);
    @(posedge clock_in);
    rstn_in <= 1;
    $display("reset test done");
    foreach (rows[i]) begin
      if (rows[i][23:19] !== cur) set_cfg(rows[i][23:21], rows[i][20:19]);
      cur = rows[i][23:19];
      u_host.read(rows[i][18:16], m, d, u);
      chk(u, rows[i][15:8] == 8'hff);
      if (rows[i][15:8] != 8'hff) begin
        chk(m, rows[i][15:8]);
        chk(d, rows[i][7:0]);
      end
    end
    $display("row test done");
    @(posedge clock_in);
    band_sel_in <= 3'h2;
    latency_code_in <= 2'h1;
    param_rd_in <= 1;
    param_addr_in <= 7'h58;
    @(posedge clock_in);
    param_rd_in <= 0;
    #1 chk(param_valid_out, 0);
    set_cfg(3'h2, 2'h1);
    $display("refuse test done");
    prd(7'h01, 8'h56);
    prd(7'h01 + 7'h56 + 7'h01, 8'hf0);
    foreach (prows[i]) prd(prows[i][14:8], prows[i][7:0]);
    $display("param test done");
    summarize();
  end
endmodule
bind latency_table_top latency_chk u_chk (.clock_in, .rstn_in,
  .latency_code_in, .param_rd_in, .param_addr_in, .param_data_out,
  .param_valid_out, .table_ready_out, .code_match_out, .band_limit_out,
  .sck_in, .cs_n_in, .mode_phase_out, .dummy_phase_out, .data_phase_out,
  .unsupported_out);
`default_nettype wire
